// ===== sim/fss_relay.sv
// Brake relay model at the far side of the drive outputs.
// Assumes drive outputs on sys_clk; the relay adds one cycle of delay.
`timescale 1ns/1ps
module fss_relay
	import fss_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire fss_drive_type drive,
	output logic               brakeHeld
);
	// Contacts open, brake applied, once either output drops
	always_ff @(posedge sys_clk) begin
		brakeHeld <= !(drive.brakeInterlock && drive.malfunctionOut);
	end
endmodule

// ===== sim/fss_top_tb.sv
// Self-checking bench of the forced stop sequencer with a brake relay model.
// Assumes the hand-over timing of the AXI4-Lite slave and of the stop sequence.
`timescale 1ns/1ps
module fss_top_tb
	import fss_pkg::*;
;
	localparam int MSD = 10;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} fss_row_type;
	logic            sys_clk = 1'b0;
	logic            rst_b;
	fss_pins_type    pins;
	logic            torqueMode, extAlarm, immAlarm, brakeHeld, encPulseOut, irq;
	logic [15:0]     speedRef, measSpeed, speedCmd, liftCmd;
	logic [7:0]      displayCode;
	fss_axi_req_type req;
	fss_axi_rsp_type rsp;
	fss_drive_type   drive;
	logic [1:0]      resp;
	logic [31:0]     rd;
	logic            ep;
	int              error_cnt = 0, checks_done = 0, cyc = 0, n;
	fss_row_type     rows [7] = '{'{OFS_CFG, 32'h31, RESP_OKAY}, '{OFS_DECEL, 32'h64, RESP_OKAY},
		'{OFS_ZERO, 32'h32, RESP_OKAY}, '{OFS_BOFF, 32'h0, RESP_OKAY},
		'{OFS_COMP, 32'h0, RESP_OKAY}, '{OFS_PULSE, 32'hfa0, RESP_OKAY},
		'{8'h28, 32'h0, RESP_SLVERR}};

	fss_top #(.MS_DIV(MSD)) DUT (.sys_clk(sys_clk), .rst_b(rst_b), .pinsRaw(pins),
		.torqueMode(torqueMode), .extAlarm(extAlarm), .immAlarm(immAlarm),
		.speedRef(speedRef), .measSpeed(measSpeed), .axiIn(req), .axiOut(rsp),
		.drive(drive), .speedCmd(speedCmd), .liftCmd(liftCmd),
		.displayCode(displayCode), .encPulseOut(encPulseOut), .irq(irq));
	fss_relay FAR (.sys_clk(sys_clk), .drive(drive), .brakeHeld(brakeHeld));

	always #20 sys_clk = ~sys_clk;

	task automatic end_sim();
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Entry waits an edge so bready or rready never changes twice in a step
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		@(posedge sys_clk);
		aw = 1'b1;
		w = 1'b1;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (aw && rsp.awready === 1'b1) begin
				aw = 1'b0;
				req.awvalid <= 1'b0;
			end
			if (w && rsp.wready === 1'b1) begin
				w = 1'b0;
				req.wvalid <= 1'b0;
			end
		end while (aw || w || rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, resp);
		chk(resp, RESP_OKAY);
	endtask

	task automatic waitRun();
		// The ramp also shows power on with the interlock held, so wait for the reference to pass through
		while (drive.powerStageOff !== 1'b0 || drive.brakeInterlock !== 1'b1 ||
			speedCmd !== speedRef) @(posedge sys_clk);
	endtask

	task automatic pulseReset();
		pins.alarmReset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		pins.alarmReset <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		rst_b <= 1'b0;
		pins <= 5'b10010;
		{torqueMode, extAlarm, immAlarm} <= 3'b000;
		speedRef <= 16'h03e8;
		measSpeed <= 16'h0000;
		req <= '0;
		repeat (2) @(posedge sys_clk);
		chk(drive, 4'b0011);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			axr(rows[i].a, rd, resp);
			chk(rd, rows[i].d);
			chk(resp, rows[i].r);
		end
		axw(OFS_STATUS, 32'h3, resp);
		chk(resp, RESP_SLVERR);
		wr(OFS_BOFF, 32'h3);
		wr(OFS_COMP, 32'h5);
		wr(OFS_IRQEN, 32'h4);
		// High rate with a slow filter; setting 3 shifted by 1 gives 6-cycle halves
		wr(OFS_PULSE, 32'h0015_0003);
		axr(OFS_STATUS, rd, resp);
		chk(rd[26], 1'b1);
		ep = encPulseOut;
		while (encPulseOut === ep) @(posedge sys_clk);
		ep = encPulseOut;
		for (n = 0; encPulseOut === ep; n++) @(posedge sys_clk);
		chk(n, 6);
		waitRun();
		chk(speedCmd, 16'h03e8);
		pins.forcedStopTwo <= 1'b0;
		repeat (5 * MSD) @(posedge sys_clk);
		chk(drive.brakeInterlock, 1'b1);
		chk(speedCmd < 16'h03e8 && speedCmd != 16'h0, 1'b1);
		chk(displayCode, WARN_STOP_CODE);
		chk(irq, 1'b0);
		for (n = 0; n < 2000 && drive.brakeInterlock !== 1'b0; n++) @(posedge sys_clk);
		@(posedge sys_clk);
		chk(drive.powerStageOff, 1'b0);
		chk(liftCmd, 16'h5);
		for (n = 0; n < 100 && drive.powerStageOff !== 1'b1; n++) @(posedge sys_clk);
		chk(n >= 2 * MSD - 2 && n <= 3 * MSD + 2, 1'b1);
		chk(drive.dynBrake, 1'b1);
		chk(brakeHeld, 1'b1);
		chk(irq, 1'b1);
		wr(OFS_IRQCLR, 32'hf);
		repeat (2) @(posedge sys_clk);
		chk(irq, 1'b0);
		// Torque mode, then selection digit 0: both skip the ramp
		for (int k = 0; k < 2; k++) begin
			pins.forcedStopTwo <= 1'b1;
			waitRun();
			torqueMode <= (k == 0);
			if (k == 1) wr(OFS_CFG, 32'h30);
			pins.forcedStopTwo <= 1'b0;
			repeat (6) @(posedge sys_clk);
			chk(drive.powerStageOff, 1'b1);
		end
		torqueMode <= 1'b0;
		wr(OFS_CFG, 32'h21);
		pins.forcedStopTwo <= 1'b1;
		waitRun();
		extAlarm <= 1'b1;
		repeat (3 * MSD) @(posedge sys_clk);
		pins.fwdStrokeEnd <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(speedCmd, 16'h0);
		chk(drive.malfunctionOut, 1'b0);
		extAlarm <= 1'b0;
		pins.fwdStrokeEnd <= 1'b0;
		pulseReset();
		chk(drive.malfunctionOut, 1'b1);
		waitRun();
		immAlarm <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(drive.powerStageOff, 1'b1);
		pulseReset();
		chk(drive.malfunctionOut, 1'b0);
		immAlarm <= 1'b0;
		pulseReset();
		chk(drive.malfunctionOut, 1'b1);
		waitRun();
		pins.forcedStopTwo <= 1'b0;
		repeat (3 * MSD) @(posedge sys_clk);
		pins.safeTorqueOn <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk(displayCode, ALARM_STO_CODE);
		chk(drive.powerStageOff, 1'b1);
		// Set button ignored while torque-off cause remains
		wr(OFS_CFG, 32'h61);
		repeat (2) @(posedge sys_clk);
		chk(drive.malfunctionOut, 1'b0);
		pins.safeTorqueOn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wr(OFS_CFG, 32'h61);
		repeat (2) @(posedge sys_clk);
		chk(drive.malfunctionOut, 1'b1);
		end_sim();
	end
endmodule

// ===== verilog/fss_pkg.sv
// Shared constants, register map and carrier types of the forced stop sequencer.
// Assumes a single 25 MHz system clock and an AXI4-Lite register bus.
package fss_pkg;
	localparam int          CLK_PERIOD_NS = 40;
	localparam int          MS_NS         = 1000000;
	localparam int          MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_W        = 8;
	localparam int          SPEED_W       = 16;

	localparam logic [7:0]  OFS_CFG     = 8'h00;
	localparam logic [7:0]  OFS_DECEL   = 8'h04;
	localparam logic [7:0]  OFS_ZERO    = 8'h08;
	localparam logic [7:0]  OFS_BOFF    = 8'h0c;
	localparam logic [7:0]  OFS_COMP    = 8'h10;
	localparam logic [7:0]  OFS_PULSE   = 8'h14;
	localparam logic [7:0]  OFS_STATUS  = 8'h18;
	localparam logic [7:0]  OFS_IRQSTAT = 8'h1c;
	localparam logic [7:0]  OFS_IRQCLR  = 8'h20;
	localparam logic [7:0]  OFS_IRQEN   = 8'h24;

	// CFG fields
	localparam int          CFG_SEL_LSB   = 0;   // forced stop selection, top digit
	localparam int          CFG_LIMSEL    = 4;
	localparam int          CFG_BOFF_EN   = 5;
	localparam int          CFG_SET_BTN   = 6;   // write 1: set button in alarm view
	// PULSE fields
	localparam int          PUL_SET_LSB   = 0;
	localparam int          PUL_SEL_LSB   = 16;
	localparam int          PUL_FILT_LSB  = 18;
	localparam int          PUL_HIRATE    = 20;
	localparam logic [1:0]  FILTER_FASTEST = 2'h0;

	localparam logic [31:0] CFG_RESET   = 32'h0000_0031;
	localparam logic [15:0] DECEL_RESET = 16'h0064;
	localparam logic [15:0] ZERO_RESET  = 16'h0032;
	localparam logic [15:0] BOFF_RESET  = 16'h0000;
	localparam logic [15:0] COMP_RESET  = 16'h0000;
	localparam logic [31:0] PULSE_RESET = 32'h0000_0fa0;

	localparam logic [7:0]  WARN_STOP_CODE = 8'he6;
	localparam logic [7:0]  ALARM_STO_CODE = 8'h63;
	localparam logic [7:0]  ALARM_EXT_CODE = 8'h10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	localparam int          IRQ_W       = 4;
	localparam int          IRQ_STOP    = 0;
	localparam int          IRQ_ALARM   = 1;
	localparam int          IRQ_OFF     = 2;
	localparam int          IRQ_STROKE  = 3;

	typedef enum logic [1:0] {FSS_RUN, FSS_DECEL, FSS_DELAY, FSS_OFF} fss_state_type;

	typedef struct packed {
		logic              forcedStopTwo;
		logic              fwdStrokeEnd;
		logic              revStrokeEnd;
		logic              safeTorqueOn;
		logic              alarmReset;
	} fss_pins_type;

	typedef struct packed {
		logic              brakeInterlock;
		logic              malfunctionOut;
		logic              powerStageOff;
		logic              dynBrake;
	} fss_drive_type;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} fss_axi_req_type;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} fss_axi_rsp_type;
endpackage

// ===== verilog/fss_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes pins change asynchronously to sys_clk; no bit pairing is kept across lanes.
`timescale 1ns/1ps
module fss_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1;

	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk) begin
			if (!rst_b) begin
				stage1[i] <= 1'b0;
				dout[i]   <= 1'b0;
			end else begin
				stage1[i] <= din[i];
				dout[i]   <= stage1[i];
			end
		end
	end
endmodule

// ===== verilog/fss_tick.sv
// Divider giving a one-cycle enable pulse every DIV clocks.
// Assumes DIV of at least 1.
`timescale 1ns/1ps
module fss_tick #(
	parameter int DIV = 25000
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	output logic      tick
);
	logic [$clog2(DIV+1)-1:0] cnt;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (cnt == ($clog2(DIV+1))'(DIV - 1)) begin
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// ===== verilog/fss_top.sv
// Forced stop sequencer: ramp-down, brake interlock, base-off delay, freefall lift, alarms.
// Assumes pins arrive raw, speed values and alarm causes come from logic on sys_clk.
// How it works
// - While forced stop two is off, no alarm is active and the stop sequence runs, the display shows code e6.
// - Forced stop two going off starts a ramp-down set by the decel time constant.
// - With the base-off delay disabled, ramp finished and speed under the zero threshold cuts the power stage and brakes.
// - A stroke end during the ramp stops at once for select 0, keeps ramping for select 1.
// - A stop or alarm ramps down, drops the brake interlock, then waits the base-off delay.
// - Freefall lift only with nonzero amount, delay enabled and speed at or under zero speed.
// - With freefall lift on, an upward move of the set amount is commanded before shut-off.
// - Alarms that brake immediately skip the ramp and brake at once.
// - Safe torque off dropping during the ramp raises torque-off timing alarm 63.
// - Torque control mode never ramps down.
// - An alarm clears on reset, the set button or a reset-input toggle, not while its cause lasts.
// - At the top pulse rate the command pulse filter must be on its fastest option; the code accepts any filter and only sets filterFault in STATUS.
// - The encoder output pulse period follows the pulse setting and pulse select.
// - Top selection digit 0 disables the ramp, so a forced stop brakes directly.
`timescale 1ns/1ps
module fss_top
	import fss_pkg::*;
#(
	parameter int                  MS_DIV      = MS_CYCLES,
	parameter logic [SPEED_W-1:0] RATED_SPEED = 16'h0bb8
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	input  wire fss_pins_type         pinsRaw,
	input  wire logic                 torqueMode,
	input  wire logic                 extAlarm,
	input  wire logic                 immAlarm,
	input  wire logic [SPEED_W-1:0]   speedRef,
	input  wire logic [SPEED_W-1:0]   measSpeed,
	input  wire fss_axi_req_type      axiIn,
	output fss_axi_rsp_type           axiOut,
	output fss_drive_type             drive,
	output logic      [SPEED_W-1:0]   speedCmd,
	output logic      [SPEED_W-1:0]   liftCmd,
	output logic      [7:0]           displayCode,
	output logic                      encPulseOut,
	output logic                      irq
);
	fss_pins_type        pins;
	fss_state_type       state;
	fss_state_type       next_state;
	logic                msTick;
	logic [31:0]         cfg;
	logic [15:0]         decelConst;
	logic [15:0]         zeroThr;
	logic [15:0]         boffDelay;
	logic [15:0]         compAmount;
	logic [31:0]         pulseCfg;
	logic [IRQ_W-1:0]    irqStat;
	logic [IRQ_W-1:0]    irqEn;
	logic [IRQ_W-1:0]    irqEvent;
	logic [IRQ_W-1:0]    irqClr;
	logic [ADDR_W-1:0]   awAddr;
	logic                awHeld;
	logic [31:0]         wData;
	logic [3:0]          wStrb;
	logic                wHeld;
	logic                doWrite;
	logic                setButton;
	logic                resetPrev;
	logic                alarmActive;
	logic [7:0]          alarmCode;
	logic                causeNow;
	logic                stopReq;
	logic                directBrake;
	logic                stoErr;
	logic                strokeHit;
	logic                sudden;
	logic [23:0]         pending;
	logic [15:0]         delayCnt;
	logic                delayDone;
	logic                freefallArm;
	logic [19:0]         encCnt;
	logic [19:0]         encHalf;
	logic                filterFault;

	fss_sync #(.W($bits(fss_pins_type))) u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.din     (pinsRaw),
		.dout    (pins)
	);

	fss_tick #(.DIV(MS_DIV)) u_tick (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.tick    (msTick)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Write address and data are taken independently, in either order
	assign doWrite = awHeld && wHeld && !axiOut.bvalid;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
			awAddr <= '0;
			wData  <= '0;
			wStrb  <= '0;
			axiOut <= '0;
		end else begin
			axiOut.awready <= !awHeld && !axiOut.awready && !axiOut.bvalid;
			axiOut.wready  <= !wHeld && !axiOut.wready && !axiOut.bvalid;
			if (axiIn.awvalid && axiOut.awready) begin
				awHeld <= 1'b1;
				awAddr <= axiIn.awaddr;
			end
			if (axiIn.wvalid && axiOut.wready) begin
				wHeld <= 1'b1;
				wData <= axiIn.wdata;
				wStrb <= axiIn.wstrb;
			end
			if (doWrite) begin
				awHeld        <= 1'b0;
				wHeld         <= 1'b0;
				axiOut.bvalid <= 1'b1;
				axiOut.bresp  <= (awAddr <= OFS_IRQEN && awAddr != OFS_STATUS &&
					awAddr != OFS_IRQSTAT && awAddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end else if (axiIn.bready && axiOut.bvalid) begin
				axiOut.bvalid <= 1'b0;
			end
			axiOut.arready <= !axiOut.arready && !axiOut.rvalid;
			if (axiIn.arvalid && axiOut.arready) begin
				axiOut.rvalid <= 1'b1;
				axiOut.rresp  <= RESP_OKAY;
				unique case (axiIn.araddr)
					OFS_CFG:     axiOut.rdata <= cfg;
					OFS_DECEL:   axiOut.rdata <= {16'h0000, decelConst};
					OFS_ZERO:    axiOut.rdata <= {16'h0000, zeroThr};
					OFS_BOFF:    axiOut.rdata <= {16'h0000, boffDelay};
					OFS_COMP:    axiOut.rdata <= {16'h0000, compAmount};
					OFS_PULSE:   axiOut.rdata <= pulseCfg;
					OFS_STATUS:  axiOut.rdata <= {5'h00, filterFault, freefallArm,
						alarmActive, alarmCode, displayCode, 6'h00, state};
					OFS_IRQSTAT: axiOut.rdata <= {28'h0000000, irqStat};
					OFS_IRQCLR:  axiOut.rdata <= '0;
					OFS_IRQEN:   axiOut.rdata <= {28'h0000000, irqEn};
					default: begin
						axiOut.rdata <= '0;
						axiOut.rresp <= RESP_SLVERR;
					end
				endcase
			end else if (axiIn.rready && axiOut.rvalid) begin
				axiOut.rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg        <= CFG_RESET;
			decelConst <= DECEL_RESET;
			zeroThr    <= ZERO_RESET;
			boffDelay  <= BOFF_RESET;
			compAmount <= COMP_RESET;
			pulseCfg   <= PULSE_RESET;
			irqEn      <= '0;
			setButton  <= 1'b0;
		end else begin
			setButton <= 1'b0;
			if (doWrite) begin
				unique case (awAddr)
					OFS_CFG: begin
						cfg       <= merge(cfg, wData, wStrb) & ~(32'h1 << CFG_SET_BTN);
						setButton <= wStrb[0] && wData[CFG_SET_BTN];
					end
					OFS_DECEL: decelConst <= 16'(merge({16'h0000, decelConst}, wData, wStrb));
					OFS_ZERO:  zeroThr    <= 16'(merge({16'h0000, zeroThr}, wData, wStrb));
					OFS_BOFF:  boffDelay  <= 16'(merge({16'h0000, boffDelay}, wData, wStrb));
					OFS_COMP:  compAmount <= 16'(merge({16'h0000, compAmount}, wData, wStrb));
					OFS_PULSE: pulseCfg   <= merge(pulseCfg, wData, wStrb);
					OFS_IRQEN: irqEn      <= IRQ_W'(merge({28'h0, irqEn}, wData, wStrb));
					default: ;
				endcase
			end
		end
	end

	assign irqClr = (doWrite && awAddr == OFS_IRQCLR && wStrb[0]) ? wData[IRQ_W-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			irqStat <= '0;
			irq     <= 1'b0;
		end else begin
			irqStat <= (irqStat & ~irqClr) | irqEvent;
			irq     <= |(((irqStat & ~irqClr) | irqEvent) & irqEn);
		end
	end

	assign stopReq     = !pins.forcedStopTwo || alarmActive;
	assign directBrake = immAlarm || torqueMode ||
		cfg[CFG_SEL_LSB +: 4] == 4'h0;
	assign stoErr      = state == FSS_DECEL && !pins.safeTorqueOn;
	assign strokeHit   = state == FSS_DECEL && (pins.fwdStrokeEnd || pins.revStrokeEnd);
	assign sudden      = strokeHit && !cfg[CFG_LIMSEL];
	assign delayDone   = delayCnt >= boffDelay;
	assign causeNow    = extAlarm || immAlarm ||
		(alarmCode == ALARM_STO_CODE && !pins.safeTorqueOn);

	always_comb begin
		next_state = state;
		unique case (state)
			FSS_RUN: begin
				if (stopReq || extAlarm || immAlarm) begin
					next_state = directBrake ? FSS_OFF : FSS_DECEL;
				end
			end
			FSS_DECEL: begin
				if (stoErr || immAlarm) begin
					next_state = FSS_OFF;
				end else if (speedCmd == '0 && measSpeed < zeroThr) begin
					next_state = cfg[CFG_BOFF_EN] ? FSS_DELAY : FSS_OFF;
				end
			end
			FSS_DELAY: begin
				if (delayDone || immAlarm) begin
					next_state = FSS_OFF;
				end
			end
			FSS_OFF: begin
				if (!stopReq && !extAlarm && !immAlarm) begin
					next_state = FSS_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state <= FSS_OFF;
			drive <= '{brakeInterlock: 1'b0, malfunctionOut: 1'b0,
				powerStageOff: 1'b1, dynBrake: 1'b1};
		end else begin
			state                <= next_state;
			drive.brakeInterlock <= next_state == FSS_RUN || next_state == FSS_DECEL;
			drive.powerStageOff  <= next_state == FSS_OFF;
			drive.dynBrake       <= next_state == FSS_OFF;
			drive.malfunctionOut <= !alarmActive;
		end
	end

	// Ramp engine: RATED_SPEED counts spread over decelConst ms
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			speedCmd <= '0;
			pending  <= '0;
		end else if (state == FSS_RUN) begin
			speedCmd <= speedRef;
			pending  <= '0;
		end else if (state == FSS_DECEL) begin
			if (sudden || decelConst == '0) begin
				speedCmd <= '0;
				pending  <= '0;
			end else if (msTick) begin
				pending <= pending + {8'h00, RATED_SPEED};
			end else if (speedCmd != '0 && pending >= {8'h00, decelConst}) begin
				pending  <= pending - {8'h00, decelConst};
				speedCmd <= speedCmd - 1'b1;
			end
		end else begin
			speedCmd <= '0;
			pending  <= '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			delayCnt    <= '0;
			freefallArm <= 1'b0;
			liftCmd     <= '0;
		end else begin
			if (state != FSS_DELAY) begin
				delayCnt <= '0;
			end else if (msTick && !delayDone) begin
				delayCnt <= delayCnt + 1'b1;
			end
			if (state == FSS_DECEL && next_state == FSS_DELAY) begin
				freefallArm <= compAmount != '0 && cfg[CFG_BOFF_EN] &&
					measSpeed <= zeroThr;
			end else if (state == FSS_RUN) begin
				freefallArm <= 1'b0;
			end
			liftCmd <= (next_state == FSS_DELAY && freefallArm) ? compAmount : '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			alarmActive <= 1'b0;
			alarmCode   <= '0;
			resetPrev   <= 1'b0;
			displayCode <= '0;
		end else begin
			resetPrev <= pins.alarmReset;
			if (stoErr) begin
				alarmActive <= 1'b1;
				alarmCode   <= ALARM_STO_CODE;
			end else if (extAlarm || immAlarm) begin
				alarmActive <= 1'b1;
				alarmCode   <= ALARM_EXT_CODE;
			end else if ((setButton || (pins.alarmReset && !resetPrev)) && !causeNow) begin
				alarmActive <= 1'b0;
				alarmCode   <= '0;
			end
			if (alarmActive) begin
				displayCode <= alarmCode;
			end else if (!pins.forcedStopTwo && state != FSS_RUN) begin
				displayCode <= WARN_STOP_CODE;
			end else begin
				displayCode <= '0;
			end
		end
	end

	assign irqEvent[IRQ_STOP]   = state == FSS_RUN && next_state != FSS_RUN;
	assign irqEvent[IRQ_ALARM]  = !alarmActive && (stoErr || extAlarm || immAlarm);
	assign irqEvent[IRQ_OFF]    = state != FSS_OFF && next_state == FSS_OFF;
	assign irqEvent[IRQ_STROKE] = strokeHit;

	// Half period = setting shifted by select; a zero setting parks the output
	assign encHalf     = 20'(pulseCfg[PUL_SET_LSB +: 16]) << pulseCfg[PUL_SEL_LSB +: 2];
	assign filterFault = pulseCfg[PUL_HIRATE] &&
		pulseCfg[PUL_FILT_LSB +: 2] != FILTER_FASTEST;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			encCnt      <= '0;
			encPulseOut <= 1'b0;
		end else if (encHalf == '0) begin
			encCnt      <= '0;
			encPulseOut <= 1'b0;
		end else if (encCnt >= encHalf - 1'b1) begin
			encCnt      <= '0;
			encPulseOut <= !encPulseOut;
		end else begin
			encCnt <= encCnt + 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_rampDone;
		state == FSS_DECEL && !stoErr && !immAlarm && speedCmd == '0 && measSpeed < zeroThr;
	endsequence
	sequence s_stopStart;
		state == FSS_RUN && (stopReq || extAlarm || immAlarm);
	endsequence

	property p_warn;
		!alarmActive && !pins.forcedStopTwo && state != FSS_RUN |=> displayCode == WARN_STOP_CODE;
	endproperty
	a_warn: assert property (p_warn) else $error("stop warning code missing");
	property p_decel;
		s_stopStart ##0 !directBrake |=> state == FSS_DECEL && drive.brakeInterlock;
	endproperty
	a_decel: assert property (p_decel) else $error("ramp not started");
	property p_cut;
		s_rampDone ##0 !cfg[CFG_BOFF_EN] |=> drive.powerStageOff && drive.dynBrake;
	endproperty
	a_cut: assert property (p_cut) else $error("power stage not cut");
	property p_sudden;
		sudden |=> speedCmd == '0;
	endproperty
	a_sudden: assert property (p_sudden) else $error("sudden stop missed");
	property p_delay;
		$rose(drive.powerStageOff) && $past(state) == FSS_DELAY |-> $past(delayDone || immAlarm);
	endproperty
	a_delay: assert property (p_delay) else $error("shut-off before delay");
	property p_lift;
		state == FSS_DELAY && next_state == FSS_DELAY && freefallArm |=> liftCmd == compAmount;
	endproperty
	a_lift: assert property (p_lift) else $error("lift not commanded");
	property p_direct;
		s_stopStart ##0 immAlarm |=> drive.powerStageOff ##1 alarmActive;
	endproperty
	a_direct: assert property (p_direct) else $error("immediate brake missed");
	property p_sto;
		stoErr |=> alarmActive && alarmCode == ALARM_STO_CODE && drive.powerStageOff;
	endproperty
	a_sto: assert property (p_sto) else $error("sto timing alarm missing");
	property p_torque;
		s_stopStart ##0 torqueMode |=> state != FSS_DECEL;
	endproperty
	a_torque: assert property (p_torque) else $error("ramp in torque mode");
	property p_hold;
		alarmActive && causeNow |=> alarmActive;
	endproperty
	a_hold: assert property (p_hold) else $error("alarm cleared with cause");
	property p_count;
		state == FSS_DELAY && msTick && !delayDone |=> delayCnt == $past(delayCnt) + 1'b1;
	endproperty
	a_count: assert property (p_count) else $error("delay count stuck");
endmodule
